// ### include/xdc_pkg.sv
// Shared constants for the fabric/transceiver datapath clocking model.
// Assumes one system clock; every transceiver or fabric clock is a one-cycle tick.
package xdc_pkg;

  // ----------------------------------------------------------------
  // Structure defaults
  // ----------------------------------------------------------------
  localparam int XDC_NCH_DEF   = 8;   // Channels sharing one interface clock
  localparam int XDC_W_DEF     = 8;   // Parallel word width
  localparam int XDC_DEPTH_DEF = 4;   // Phase-compensation FIFO depth

  // ----------------------------------------------------------------
  // Shared-clock source choice in the fabric
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    XDC_SRC_FWD,    // Forwarded clock of a chosen channel
    XDC_SRC_CH0,    // Channel-zero forwarded clock (bonded)
    XDC_SRC_REF     // Dedicated reference clock pin
  } xdc_src_e;

endpackage

// ### include/xdc_link_if.sv
// Parallel datapath between the transceiver channels and fabric user logic.
// Assumes both ends share clk; interface clocks are carried as tick strobes.
`timescale 1ns/1ns
interface xdc_link_if
#(
  parameter int NCH = xdc_pkg::XDC_NCH_DEF,
  parameter int W   = xdc_pkg::XDC_W_DEF
);
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic [NCH-1:0]        tx_clkfwd;     // Forwarded transmit interface clock
  logic [NCH-1:0]        rx_clkfwd;     // Forwarded receive interface clock
  logic [NCH-1:0]        tx_core_tick;  // Fabric clock into transmit FIFO write
  logic [NCH-1:0]        rx_core_tick;  // Fabric clock into receive FIFO read
  logic [NCH-1:0][W-1:0] tx_data;       // Fabric to transceiver words
  logic [NCH-1:0][W-1:0] rx_data;       // Transceiver to fabric words
  logic [NCH-1:0]        rx_valid;      // Receive word presented this cycle

  modport dev (input tx_core_tick, rx_core_tick, tx_data,
               output tx_clkfwd, rx_clkfwd, rx_data, rx_valid);
  modport fab (output tx_core_tick, rx_core_tick, tx_data,
               input tx_clkfwd, rx_clkfwd, rx_data, rx_valid);
endinterface

// ### hw/xdc_chan_dev.sv
// Transceiver end: per-channel phase-compensation FIFOs and clock forwarding.
// Assumes the fabric end drives the core ticks from one legal shared source.
`timescale 1ns/1ns
module xdc_chan_dev
#(
  parameter int NCH   = xdc_pkg::XDC_NCH_DEF,
  parameter int W     = xdc_pkg::XDC_W_DEF,
  parameter int DEPTH = xdc_pkg::XDC_DEPTH_DEF
)
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  xdc_link_if.dev                    link,
  input  wire logic                  bonded,
  input  wire logic                  rate_match,
  input  wire logic                  direct_10g,
  input  wire logic [NCH-1:0]        chan_rst,
  input  wire logic [NCH-1:0]        tx_pma_tick,
  input  wire logic [NCH-1:0]        rx_rec_tick,
  input  wire logic [NCH-1:0]        rx_div_tick,
  input  wire logic [NCH-1:0][W-1:0] rx_des_data,
  input  wire logic                  flag_clr,
  output logic      [NCH-1:0][W-1:0] tx_ser_data,
  output logic      [NCH-1:0]        tx_ser_valid,
  output logic      [NCH-1:0]        tx_ovf,
  output logic      [NCH-1:0]        tx_udr,
  output logic      [NCH-1:0]        rx_ovf,
  output logic      [NCH-1:0]        rx_udr
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  // Wrapping pointer advance, shared by all four FIFO ports
  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == LAST_PTR) ? '0 : p + PW'(1);
  endfunction

  // ----------------------------------------------------------------
  // Clock forwarding
  // ----------------------------------------------------------------
  // A channel held in reset adds no tick of its own; in bonded mode it still forwards channel zero's, on rx only outside direct mode
  wire logic [NCH-1:0] tx_live = tx_pma_tick & ~chan_rst;
  wire logic [NCH-1:0] rec_live = rx_rec_tick & ~chan_rst;
  wire logic [NCH-1:0] div_live = rx_div_tick & ~chan_rst;
  logic [NCH-1:0] tx_fwd_next;
  logic [NCH-1:0] rx_fwd_next;
  logic [NCH-1:0] rx_wr_tick;

  // Forwarded clock choice per channel
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      tx_fwd_next[c] = bonded ? tx_live[0] : tx_live[c];
      if (direct_10g)
        rx_fwd_next[c] = rec_live[c];
      else if (bonded)
        rx_fwd_next[c] = div_live[0];
      else
        rx_fwd_next[c] = rate_match ? tx_live[c] : rec_live[c];
      rx_wr_tick[c] = rate_match ? div_live[c] : rec_live[c];
    end
  end

  // Forwarded ticks leave from flip-flops
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      link.tx_clkfwd <= '0;
      link.rx_clkfwd <= '0;
    end
    else
    begin
      link.tx_clkfwd <= tx_fwd_next;
      link.rx_clkfwd <= rx_fwd_next;
    end
  end

  // ----------------------------------------------------------------
  // Per-channel FIFOs
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    logic [W-1:0]  tx_mem [DEPTH];
    logic [W-1:0]  rx_mem [DEPTH];
    logic [PW-1:0] tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
    logic [CW-1:0] tx_cnt_reg, rx_cnt_reg;

    // Direct mode bypasses both FIFOs entirely
    wire logic pcs    = ~direct_10g & ~chan_rst[c];
    wire logic tx_wr  = pcs & link.tx_core_tick[c];
    wire logic tx_rd  = pcs & tx_pma_tick[c];
    wire logic rx_wr  = pcs & rx_wr_tick[c];
    wire logic rx_rd  = pcs & link.rx_core_tick[c];
    // A simultaneous read makes room, so a write at full is then legal
    wire logic tx_ovf_ev = tx_wr & (tx_cnt_reg == FULL_CNT) & ~tx_rd;
    wire logic tx_udr_ev = tx_rd & (tx_cnt_reg == '0);
    wire logic rx_ovf_ev = rx_wr & (rx_cnt_reg == FULL_CNT) & ~rx_rd;
    wire logic rx_udr_ev = rx_rd & (rx_cnt_reg == '0);
    wire logic tx_push = tx_wr & ~tx_ovf_ev;
    wire logic tx_pop  = tx_rd & ~tx_udr_ev;
    wire logic rx_push = rx_wr & ~rx_ovf_ev;
    wire logic rx_pop  = rx_rd & ~rx_udr_ev;

    // Storage writes; no reset needed on the data itself
    always_ff @(posedge clk)
    begin
      if (tx_push)
        tx_mem[tx_wp_reg] <= link.tx_data[c];
      if (rx_push)
        rx_mem[rx_wp_reg] <= rx_des_data[c];
    end

    // Pointers and fill counts; channel reset empties both FIFOs
    always_ff @(posedge clk)
    begin
      if (rst || chan_rst[c])
      begin
        tx_wp_reg  <= '0;
        tx_rp_reg  <= '0;
        tx_cnt_reg <= '0;
        rx_wp_reg  <= '0;
        rx_rp_reg  <= '0;
        rx_cnt_reg <= '0;
      end
      else
      begin
        if (tx_push)
          tx_wp_reg <= ptr_inc(tx_wp_reg);
        if (tx_pop)
          tx_rp_reg <= ptr_inc(tx_rp_reg);
        tx_cnt_reg <= tx_cnt_reg + CW'(tx_push) - CW'(tx_pop);
        if (rx_push)
          rx_wp_reg <= ptr_inc(rx_wp_reg);
        if (rx_pop)
          rx_rp_reg <= ptr_inc(rx_rp_reg);
        rx_cnt_reg <= rx_cnt_reg + CW'(rx_push) - CW'(rx_pop);
      end
    end

    // Serializer and fabric-side outputs
    always_ff @(posedge clk)
    begin
      if (rst)
      begin
        tx_ser_data[c]  <= '0;
        tx_ser_valid[c] <= 1'b0;
        link.rx_data[c] <= '0;
        link.rx_valid[c] <= 1'b0;
      end
      else if (direct_10g)
      begin
        tx_ser_data[c]  <= link.tx_data[c];
        tx_ser_valid[c] <= link.tx_core_tick[c] & ~chan_rst[c];
        link.rx_data[c] <= rx_des_data[c];
        link.rx_valid[c] <= rec_live[c];
      end
      else
      begin
        tx_ser_data[c]  <= tx_pop ? tx_mem[tx_rp_reg] : tx_ser_data[c];
        tx_ser_valid[c] <= tx_pop;
        link.rx_data[c] <= rx_pop ? rx_mem[rx_rp_reg] : link.rx_data[c];
        link.rx_valid[c] <= rx_pop;
      end
    end

    // Sticky offset flags; a new event wins over a clear
    always_ff @(posedge clk)
    begin
      if (rst)
      begin
        tx_ovf[c] <= 1'b0;
        tx_udr[c] <= 1'b0;
        rx_ovf[c] <= 1'b0;
        rx_udr[c] <= 1'b0;
      end
      else
      begin
        tx_ovf[c] <= tx_ovf_ev | (tx_ovf[c] & ~flag_clr);
        tx_udr[c] <= tx_udr_ev | (tx_udr[c] & ~flag_clr);
        rx_ovf[c] <= rx_ovf_ev | (rx_ovf[c] & ~flag_clr);
        rx_udr[c] <= rx_udr_ev | (rx_udr[c] & ~flag_clr);
      end
    end
  end

endmodule

// ### hw/xdc_fab_user.sv
// Fabric end: picks one shared interface clock per direction for all channels.
// Assumes the chosen source is frequency-locked to the FIFO far side.
`timescale 1ns/1ns
module xdc_fab_user
#(
  parameter int NCH = xdc_pkg::XDC_NCH_DEF,
  parameter int W   = xdc_pkg::XDC_W_DEF,
  parameter int SW  = (NCH > 1) ? $clog2(NCH) : 1
)
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  xdc_link_if.fab                    link,
  input  xdc_pkg::xdc_src_e          tx_src_sel,
  input  wire logic [SW-1:0]         tx_src_chan,
  input  xdc_pkg::xdc_src_e          rx_src_sel,
  input  wire logic [SW-1:0]         rx_src_chan,
  input  wire logic                  ref_tick,
  input  wire logic [NCH-1:0][W-1:0] tx_user_data,
  output logic                       tx_user_taken,
  output logic      [NCH-1:0][W-1:0] rx_user_data,
  output logic      [NCH-1:0]        rx_user_valid
);

  // Pick one clock from the legal list; never a gated or built clock
  function automatic logic pick(input xdc_pkg::xdc_src_e sel,
                                input logic [NCH-1:0] fwd,
                                input logic [SW-1:0] chan,
                                input logic rf);
    unique case (sel)
      xdc_pkg::XDC_SRC_FWD: pick = fwd[chan];
      xdc_pkg::XDC_SRC_CH0: pick = fwd[0];
      xdc_pkg::XDC_SRC_REF: pick = rf;   // Zero offset is the user's to ensure
      default:              pick = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Shared clock choice
  // ----------------------------------------------------------------
  wire logic tx_shared = pick(tx_src_sel, link.tx_clkfwd, tx_src_chan, ref_tick);
  wire logic rx_shared = pick(rx_src_sel, link.rx_clkfwd, rx_src_chan, ref_tick);

  // One tick drives every channel's core port together with its data
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      link.tx_core_tick <= '0;
      link.rx_core_tick <= '0;
      link.tx_data      <= '0;
      tx_user_taken     <= 1'b0;
    end
    else
    begin
      link.tx_core_tick <= {NCH{tx_shared}};
      link.rx_core_tick <= {NCH{rx_shared}};
      tx_user_taken     <= tx_shared;
      if (tx_shared)
        link.tx_data <= tx_user_data;
    end
  end

  // Receive words captured as the transceiver presents them
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_user_data  <= '0;
      rx_user_valid <= '0;
    end
    else
    begin
      rx_user_valid <= link.rx_valid;
      for (int c = 0; c < NCH; c++)
        if (link.rx_valid[c])
          rx_user_data[c] <= link.rx_data[c];
    end
  end

endmodule

// ### sim/xdc_link_chk.sv
// Concurrent checks on the link between the transceiver end and the fabric end.
// Assumes one clock; link signals and a few mode levels arrive as plain inputs.
`timescale 1ns/1ns
module xdc_link_chk
#(
  parameter int NCH = 8
)
(
  input wire logic           clk,
  input wire logic           rst,
  input wire logic           bonded,
  input wire logic           direct_10g,
  input wire logic           ref_tick,
  input wire logic [NCH-1:0] tx_clkfwd,
  input wire logic [NCH-1:0] rx_clkfwd,
  input wire logic [NCH-1:0] tx_core_tick,
  input wire logic [NCH-1:0] rx_core_tick,
  input wire logic [NCH-1:0] rx_valid
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // One shared source must reach every channel in the same cycle
  property p_tx_same; tx_core_tick == '0 || tx_core_tick == '1; endproperty
  a_tx_same: assert property (p_tx_same) else $error("tx core ticks differ");
  property p_rx_same; rx_core_tick == '0 || rx_core_tick == '1; endproperty
  a_rx_same: assert property (p_rx_same) else $error("rx core ticks differ");
  // Bonded: tx always, and rx outside direct mode, forward channel zero only, so those bits agree
  property p_tx_bond; bonded && $past(bonded) |-> tx_clkfwd == '0 || tx_clkfwd == '1; endproperty
  a_tx_bond: assert property (p_tx_bond) else $error("bonded tx forward split");
  property p_rx_bond; bonded && $past(bonded) && !direct_10g |-> rx_clkfwd == '0 || rx_clkfwd == '1; endproperty
  a_rx_bond: assert property (p_rx_bond) else $error("bonded rx forward split");
  // Outside direct mode a receive word only ever answers a fabric read one cycle earlier
  property p_rx_read; !direct_10g && !$past(direct_10g) |-> (rx_valid & ~$past(rx_core_tick)) == '0; endproperty
  a_rx_read: assert property (p_rx_read) else $error("rx word without read");
  // Shared tick is never made up in logic: it follows a real source
  property p_tx_src; tx_core_tick != '0 |-> $past(tx_clkfwd) != '0 || $past(ref_tick); endproperty
  a_tx_src: assert property (p_tx_src) else $error("tx core tick without source");
  property p_rx_src; rx_core_tick != '0 |-> $past(rx_clkfwd) != '0 || $past(ref_tick); endproperty
  a_rx_src: assert property (p_rx_src) else $error("rx core tick without source");
  // Reset leaves the link silent at release
  property p_rst_quiet; $fell(rst) |-> tx_clkfwd == '0 && rx_clkfwd == '0 && rx_valid == '0; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("link busy after reset");

  // Main scenarios reached
  c_bond: cover property (bonded && tx_clkfwd == '1);
  c_read: cover property (rx_valid[0] && !direct_10g);
  c_ref: cover property ($past(ref_tick) && tx_core_tick[0]);
endmodule

// ### sim/xcvr_fabric_datapath_clocking_test.sv
// Self-checking bench: both link ends joined through the link interface.
// Assumes the package and interface files are compiled first.
`timescale 1ns/1ns
module xcvr_fabric_datapath_clocking_test;
  // ----------------------------------------------------------------
  // Stimulus, results and rows
  // ----------------------------------------------------------------
  localparam int NCH = 8;
  localparam int W   = 8;
  typedef struct packed {logic [2:0] mode; logic [7:0] td; logic [7:0] rd;} xdc_row_s;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  bonded = 1'b0, rate_match = 1'b0, direct_10g = 1'b0, flag_clr = 1'b0, ref_tick = 1'b0;
  logic [NCH-1:0]        chan_rst = '0, tx_pma_tick = '0, rx_rec_tick = '0, rx_div_tick = '0;
  logic [NCH-1:0][W-1:0] rx_des_data = '0, tx_user_data = '0, tx_seen, rx_seen, ex_tx, ex_rx;
  xdc_pkg::xdc_src_e     tx_src_sel = xdc_pkg::XDC_SRC_REF, rx_src_sel = xdc_pkg::XDC_SRC_REF;
  logic [2:0]            tx_src_chan = 3'h0, rx_src_chan = 3'h0;
  logic [NCH-1:0][W-1:0] tx_ser_data, rx_user_data;
  logic [NCH-1:0]        tx_ser_valid, tx_ovf, tx_udr, rx_ovf, rx_udr, rx_user_valid;
  logic                  tx_user_taken;
  int                    mismatches = 0, checks = 0;
  int                    taken_cnt = 0;
  // Mode {bonded, rate match, direct}, transmit base word, receive base word
  xdc_row_s rows [4] = '{'{3'h0, 8'h10, 8'h80}, '{3'h2, 8'h20, 8'h90}, '{3'h6, 8'h30, 8'hA0}, '{3'h1, 8'h40, 8'hB0}};

  always #20 clk = ~clk;

  xdc_link_if #(.NCH(NCH), .W(W)) lnk ();
  xdc_chan_dev #(.NCH(NCH), .W(W)) i_xdc_chan_dev (.clk, .rst, .link(lnk), .bonded, .rate_match, .direct_10g,
    .chan_rst, .tx_pma_tick, .rx_rec_tick, .rx_div_tick, .rx_des_data, .flag_clr, .tx_ser_data, .tx_ser_valid,
    .tx_ovf, .tx_udr, .rx_ovf, .rx_udr);
  xdc_fab_user #(.NCH(NCH), .W(W)) i_xdc_fab_user (.clk, .rst, .link(lnk), .tx_src_sel, .tx_src_chan,
    .rx_src_sel, .rx_src_chan, .ref_tick, .tx_user_data, .tx_user_taken, .rx_user_data, .rx_user_valid);
  xdc_link_chk #(.NCH(NCH)) i_xdc_link_chk (.clk, .rst, .bonded, .direct_10g, .ref_tick,
    .tx_clkfwd(lnk.tx_clkfwd), .rx_clkfwd(lnk.rx_clkfwd), .tx_core_tick(lnk.tx_core_tick),
    .rx_core_tick(lnk.rx_core_tick), .rx_valid(lnk.rx_valid));

  // Catch delivered words, since valid stands one cycle only
  always @(posedge clk)
  begin
    if (tx_ser_valid[0] === 1'b1) tx_seen <= tx_ser_data;
    if (rx_user_valid[0] === 1'b1) rx_seen <= rx_user_data;
    if (tx_user_taken === 1'b1) taken_cnt <= taken_cnt + 1;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic finish_test();
    if (mismatches == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One tick burst; forwarded clocks a cycle later, shared core ticks one more cycle on
  task automatic fwd(input logic [2:0] m, input logic [7:0] cr, p, r, d, et, er, ect, ecr);
    {bonded, rate_match, direct_10g} = m;
    chan_rst = cr;
    tx_pma_tick = p;
    rx_rec_tick = r;
    rx_div_tick = d;
    step();
    tx_pma_tick = '0;
    rx_rec_tick = '0;
    rx_div_tick = '0;
    chk("tx_clkfwd", 64'(et), 64'(lnk.tx_clkfwd));
    chk("rx_clkfwd", 64'(er), 64'(lnk.rx_clkfwd));
    step();
    chk("tx_core_tick", 64'(ect), 64'(lnk.tx_core_tick));
    chk("rx_core_tick", 64'(ecr), 64'(lnk.rx_core_tick));
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) step();
    rst = 1'b0;
    // Ordinary transfers, one word each way per mode
    foreach (rows[i])
    begin
      {bonded, rate_match, direct_10g} = rows[i].mode; // one setup shared by all channels
      for (int c = 0; c < NCH; c++)
      begin
        ex_tx[c] = rows[i].td + 8'(c);
        ex_rx[c] = rows[i].rd + 8'(c);
      end
      tx_user_data = ex_tx;
      rx_des_data = ex_rx;
      tx_seen = 'x;
      rx_seen = 'x;
      taken_cnt = 0;
      rx_rec_tick = '1;
      rx_div_tick = '1;
      step();
      rx_rec_tick = '0;
      rx_div_tick = '0;
      ref_tick = 1'b1;
      step();
      ref_tick = 1'b0;
      repeat (2) step();
      tx_pma_tick = '1;
      step();
      tx_pma_tick = '0;
      repeat (6) step();
      chk("tx_ser_data", ex_tx, tx_seen);
      chk("rx_user_data", ex_rx, rx_seen);
      chk("tx_user_taken", 64'h1, 64'(taken_cnt));
      chk("flags", 64'h0, 64'({tx_ovf, tx_udr, rx_ovf, rx_udr}));
    end
    // Fabric tick faster than the device side: tx fills, rx starves
    {bonded, rate_match, direct_10g} = 3'h0;
    flag_clr = 1'b1;
    step();
    flag_clr = 1'b0;
    ref_tick = 1'b1;
    repeat (5) step();
    ref_tick = 1'b0;
    repeat (4) step();
    chk("fast flags", 64'(32'hFF0000FF), 64'({tx_ovf, tx_udr, rx_ovf, rx_udr}));
    // Fabric tick slower: tx drains past empty, rx overfills
    flag_clr = 1'b1;
    step();
    flag_clr = 1'b0;
    tx_pma_tick = '1;
    rx_rec_tick = '1;
    repeat (5) step();
    tx_pma_tick = '0;
    rx_rec_tick = '0;
    repeat (4) step();
    chk("slow flags", 64'(32'h00FFFF00), 64'({tx_ovf, tx_udr, rx_ovf, rx_udr}));
    // Underrun on the empty tx FIFO in the very cycle of a clear: the event must win
    flag_clr = 1'b1;
    tx_pma_tick = '1;
    step();
    flag_clr = 1'b0;
    tx_pma_tick = '0;
    step();
    chk("clear vs set", 64'(32'h00FF0000), 64'({tx_ovf, tx_udr, rx_ovf, rx_udr}));
    // Clock forwarding per mode, both forwarded shared-source choices, and loss under channel reset
    tx_src_sel = xdc_pkg::XDC_SRC_FWD;
    tx_src_chan = 3'h4;
    rx_src_sel = xdc_pkg::XDC_SRC_CH0;
    fwd(3'h6, 8'h00, 8'h01, 8'h00, 8'h01, 8'hFF, 8'hFF, 8'hFF, 8'hFF);
    fwd(3'h2, 8'h00, 8'h5A, 8'hA5, 8'h00, 8'h5A, 8'h5A, 8'hFF, 8'h00);
    fwd(3'h0, 8'h00, 8'h5A, 8'hA5, 8'h00, 8'h5A, 8'hA5, 8'hFF, 8'hFF);
    tx_src_sel = xdc_pkg::XDC_SRC_CH0;
    rx_src_sel = xdc_pkg::XDC_SRC_FWD;
    rx_src_chan = 3'h1;
    fwd(3'h1, 8'h00, 8'h5A, 8'hA5, 8'h00, 8'h5A, 8'hA5, 8'h00, 8'h00);
    fwd(3'h0, 8'h0F, 8'hFF, 8'hFF, 8'h00, 8'hF0, 8'hF0, 8'h00, 8'h00);
    fwd(3'h6, 8'h01, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00);
    chan_rst = '0;
    // Second reset in mid-run clears sticky state
    rst = 1'b1;
    repeat (3) step();
    rst = 1'b0;
    step();
    chk("after reset", 64'h0, 64'({tx_ovf, tx_udr, rx_ovf, rx_udr, tx_ser_valid, rx_user_valid}));
    finish_test();
  end

  // Watchdog: the whole sequence needs well under 200 cycles
  initial
  begin
    #40000;
    mismatches++;
    finish_test();
  end
endmodule
